/* logic/slls_pkg.sv */
package slls_pkg;

  // ----------------------------------------------------------------
  // Lane status byte layout
  // ----------------------------------------------------------------
  localparam int unsigned BIT_CODEGROUP = 0;
  localparam int unsigned BIT_FRAME = 1;
  localparam int unsigned BIT_CHECKSUM = 2;
  localparam int unsigned BIT_INIT_ALIGN = 3;
  localparam int unsigned BIT_DESKEW = 4;
  localparam int unsigned BIT_BAD_CTRL = 5;
  localparam int unsigned BIT_INVALID = 6;
  localparam int unsigned BIT_DISPARITY = 7;
  localparam logic [7:0] LINK_STATUS_RST = 8'h00;

  // ----------------------------------------------------------------
  // Register indices; the byte address is four times the index
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 14;
  localparam logic [11:0] IDX_PAGE_SEL = 12'h300;
  localparam logic [11:0] IDX_LANE0_STATUS = 12'h4b0;
  localparam logic [11:0] IDX_LANE1_STATUS = 12'h4b1;
  localparam logic [11:0] IDX_IRQ_STATUS = 12'h4c0;
  localparam logic [11:0] IDX_IRQ_MASK = 12'h4c1;

  // ----------------------------------------------------------------
  // Interrupt status bits and bus constants
  // ----------------------------------------------------------------
  localparam int unsigned IRQ_W = 4;
  localparam int unsigned IRQ_L0_ERR = 0;
  localparam int unsigned IRQ_L0_SYNC_LOSS = 1;
  localparam int unsigned IRQ_L1_ERR = 2;
  localparam int unsigned IRQ_L1_SYNC_LOSS = 3;
  localparam logic [3:0] IRQ_MASK_RST = 4'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [31:0] DATA_RST = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Live inputs of one lane
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] disparity_cnt;
    logic [7:0] invalid_cnt;
    logic [7:0] bad_ctrl_cnt;
    logic deskew_done;
    logic initial_align_ok;
    logic checksum_ok;
    logic frame_align_ok;
    logic codegroup_align_ok;
  } slls_lane_in_t;

  function automatic logic [ADDR_W-1:0] byte_addr(input logic [11:0] idx);
    byte_addr = {idx, 2'b00};
  endfunction

endpackage

/* logic/slls_lane_status.sv */
`timescale 1ns/100ps
module slls_lane_status (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Live lane state and threshold.
  input wire slls_pkg::slls_lane_in_t lane_in,
  input wire logic [7:0] error_threshold,
  // Status byte.
  output logic [7:0] status_q
);

  // ----------------------------------------------------------------
  // Threshold compare
  // ----------------------------------------------------------------
  function automatic logic at_or_above(input logic [7:0] cnt, input logic [7:0] thr);
    at_or_above = (cnt >= thr);
  endfunction

  // The byte follows the live inputs every cycle; a bit clears on the next clock edge after its input drops.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_q <= slls_pkg::LINK_STATUS_RST;
    end else begin
      status_q[slls_pkg::BIT_BAD_CTRL] <= at_or_above(lane_in.bad_ctrl_cnt, error_threshold);
      status_q[slls_pkg::BIT_INVALID] <= at_or_above(lane_in.invalid_cnt, error_threshold);
      status_q[slls_pkg::BIT_DISPARITY] <= at_or_above(lane_in.disparity_cnt, error_threshold);
      status_q[slls_pkg::BIT_DESKEW] <= lane_in.deskew_done;
      status_q[slls_pkg::BIT_INIT_ALIGN] <= lane_in.initial_align_ok;
      status_q[slls_pkg::BIT_CHECKSUM] <= lane_in.checksum_ok;
      status_q[slls_pkg::BIT_FRAME] <= lane_in.frame_align_ok;
      status_q[slls_pkg::BIT_CODEGROUP] <= lane_in.codegroup_align_ok;
    end
  end

  chk_thresh_equal: assert property (@(posedge aclk) disable iff (!aresetn)
    (lane_in.bad_ctrl_cnt == error_threshold) |=> status_q[slls_pkg::BIT_BAD_CTRL])
    else $error("Flag not set when count equals threshold.");
  chk_thresh_below: assert property (@(posedge aclk) disable iff (!aresetn)
    (lane_in.disparity_cnt < error_threshold) |=> !status_q[slls_pkg::BIT_DISPARITY])
    else $error("Flag set while count is below threshold.");

endmodule

/* logic/slls_event_irq.sv */
`timescale 1ns/100ps
module slls_event_irq (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Lane status bytes and software controls.
  input wire logic [1:0][7:0] lane_status,
  input wire logic [slls_pkg::IRQ_W-1:0] irq_mask,
  input wire logic status_read,
  // Sticky status and interrupt.
  output logic [slls_pkg::IRQ_W-1:0] irq_status_q,
  output logic irq_q
);

  logic [1:0][7:0] prev_q;
  logic [slls_pkg::IRQ_W-1:0] set_ev;
  logic [slls_pkg::IRQ_W-1:0] status_d;

  // ----------------------------------------------------------------
  // Events: an error flag rising, or a sync result falling
  // ----------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      set_ev[2*i] = |(lane_status[i][7:5] & ~prev_q[i][7:5]);
      set_ev[2*i+1] = |(prev_q[i][4:0] & ~lane_status[i][4:0]);
    end
    status_d = (status_read ? '0 : irq_status_q) | set_ev;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_q <= '0;
    end else begin
      prev_q <= lane_status;
    end
  end

  // A set in the cycle of the clearing read wins over the clear.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status_q <= '0;
      irq_q <= 1'b0;
    end else begin
      irq_status_q <= status_d;
      irq_q <= |(status_d & irq_mask);
    end
  end

  chk_set_wins: assert property (@(posedge aclk) disable iff (!aresetn)
    (status_read && set_ev[0]) |=> irq_status_q[0])
    else $error("Event lost during clearing read.");

endmodule

/* logic/slls_top.sv */
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/100ps
module slls_top #(
  parameter int unsigned NUM_LINKS = 2
) (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Lane state per link and threshold.
  input wire slls_pkg::slls_lane_in_t [NUM_LINKS-1:0][1:0] lane_in,
  input wire logic [7:0] error_threshold,
  input wire logic [$clog2(NUM_LINKS)-1:0] link_page,
  // Write address channel.
  input wire logic [slls_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // Write data channel.
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // Write response channel.
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Read address channel.
  input wire logic [slls_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // Read data channel.
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Interrupt.
  output logic irq
);

  slls_pkg::slls_lane_in_t [1:0] sel_in;
  logic [1:0][7:0] lane_status;
  logic [slls_pkg::IRQ_W-1:0] irq_status;
  logic [slls_pkg::IRQ_W-1:0] irq_mask_q;
  logic [slls_pkg::ADDR_W-1:0] aw_addr_q;
  logic aw_held_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic w_held_q;
  logic wr_go;
  logic rd_take;
  logic status_read;

  function automatic logic hit(input logic [slls_pkg::ADDR_W-1:0] addr, input logic [11:0] idx);
    hit = (addr == slls_pkg::byte_addr(idx));
  endfunction

  function automatic logic mapped(input logic [slls_pkg::ADDR_W-1:0] addr);
    mapped = hit(addr, slls_pkg::IDX_LANE0_STATUS) || hit(addr, slls_pkg::IDX_LANE1_STATUS) ||
             hit(addr, slls_pkg::IDX_IRQ_STATUS) || hit(addr, slls_pkg::IDX_IRQ_MASK);
  endfunction

  // ----------------------------------------------------------------
  // Link page selection
  // ----------------------------------------------------------------
  // A page beyond the implemented links selects all-zero lane inputs.
  always_comb begin
    if (link_page < NUM_LINKS) begin
      sel_in = lane_in[link_page];
    end else begin
      sel_in = '0;
    end
  end

  // ----------------------------------------------------------------
  // Lane status bytes
  // ----------------------------------------------------------------
  slls_lane_status u_lane0 (
    .aclk(aclk),
    .aresetn(aresetn),
    .lane_in(sel_in[0]),
    .error_threshold(error_threshold),
    .status_q(lane_status[0])
  );

  slls_lane_status u_lane1 (
    .aclk(aclk),
    .aresetn(aresetn),
    .lane_in(sel_in[1]),
    .error_threshold(error_threshold),
    .status_q(lane_status[1])
  );

  // ----------------------------------------------------------------
  // Event status and interrupt
  // ----------------------------------------------------------------
  slls_event_irq u_irq (
    .aclk(aclk),
    .aresetn(aresetn),
    .lane_status(lane_status),
    .irq_mask(irq_mask_q),
    .status_read(status_read),
    .irq_status_q(irq_status),
    .irq_q(irq)
  );

  // ----------------------------------------------------------------
  // Write channels
  // ----------------------------------------------------------------
  assign wr_go = aw_held_q && w_held_q && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      aw_held_q <= 1'b0;
      aw_addr_q <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      aw_held_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
      aw_held_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b1;
      w_held_q <= 1'b0;
      w_data_q <= slls_pkg::DATA_RST;
      w_strb_q <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      w_held_q <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
      w_held_q <= 1'b0;
    end
  end

  // Writes to the read-only status bytes are ignored and answered OKAY.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= slls_pkg::RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= mapped(aw_addr_q) ? slls_pkg::RESP_OKAY : slls_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_mask_q <= slls_pkg::IRQ_MASK_RST;
    end else if (wr_go && hit(aw_addr_q, slls_pkg::IDX_IRQ_MASK) && w_strb_q[0]) begin
      irq_mask_q <= w_data_q[slls_pkg::IRQ_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Read channels
  // ----------------------------------------------------------------
  assign rd_take = s_axi_arvalid && s_axi_arready;
  assign status_read = rd_take && hit(s_axi_araddr, slls_pkg::IDX_IRQ_STATUS);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
    end else if (rd_take) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
    end
  end

  // Lane bytes are returned as held; the read itself changes nothing.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rdata <= slls_pkg::DATA_RST;
      s_axi_rresp <= slls_pkg::RESP_OKAY;
    end else if (rd_take) begin
      s_axi_rresp <= mapped(s_axi_araddr) ? slls_pkg::RESP_OKAY : slls_pkg::RESP_SLVERR;
      if (hit(s_axi_araddr, slls_pkg::IDX_LANE0_STATUS)) begin
        s_axi_rdata <= {24'h00_0000, lane_status[0]};
      end else if (hit(s_axi_araddr, slls_pkg::IDX_LANE1_STATUS)) begin
        s_axi_rdata <= {24'h00_0000, lane_status[1]};
      end else if (hit(s_axi_araddr, slls_pkg::IDX_IRQ_STATUS)) begin
        s_axi_rdata <= {28'h000_0000, irq_status};
      end else if (hit(s_axi_araddr, slls_pkg::IDX_IRQ_MASK)) begin
        s_axi_rdata <= {28'h000_0000, irq_mask_q};
      end else begin
        s_axi_rdata <= slls_pkg::DATA_RST;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_lane0_bad_ctrl: assert property (@(posedge aclk) disable iff (!aresetn)
    1'b1 |=> lane_status[0][5] == ($past(sel_in[0].bad_ctrl_cnt) >= $past(error_threshold)))
    else $error("Lane 0 control character flag wrong.");

  chk_lane1_invalid: assert property (@(posedge aclk) disable iff (!aresetn)
    1'b1 |=> lane_status[1][6] == ($past(sel_in[1].invalid_cnt) >= $past(error_threshold)))
    else $error("Lane 1 invalid code flag wrong.");

  chk_lane1_disparity: assert property (@(posedge aclk) disable iff (!aresetn)
    (sel_in[1].disparity_cnt >= error_threshold) |=> lane_status[1][7])
    else $error("Lane 1 disparity flag not set.");

  chk_sync_bits: assert property (@(posedge aclk) disable iff (!aresetn)
    1'b1 |=> lane_status[1][4:0] == {$past(sel_in[1].deskew_done), $past(sel_in[1].initial_align_ok),
      $past(sel_in[1].checksum_ok), $past(sel_in[1].frame_align_ok), $past(sel_in[1].codegroup_align_ok)})
    else $error("Lane 1 sync results wrong.");

  chk_lane0_frame: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(sel_in[0].frame_align_ok) |=> !lane_status[0][1])
    else $error("Lane 0 frame loss not shown.");

  chk_page_select: assert property (@(posedge aclk) disable iff (!aresetn)
    ($changed(link_page) && lane_in[link_page][0].codegroup_align_ok) |=> lane_status[0][0])
    else $error("Page change not reflected.");

  chk_lane0_read: assert property (@(posedge aclk) disable iff (!aresetn)
    (rd_take && hit(s_axi_araddr, slls_pkg::IDX_LANE0_STATUS)) |=>
      s_axi_rvalid && s_axi_rdata == {24'h00_0000, $past(lane_status[0])})
    else $error("Lane 0 read data wrong.");

  chk_lane1_read: assert property (@(posedge aclk) disable iff (!aresetn)
    (rd_take && hit(s_axi_araddr, slls_pkg::IDX_LANE1_STATUS)) |=>
      s_axi_rresp == slls_pkg::RESP_OKAY && s_axi_rdata[31:8] == 24'h00_0000)
    else $error("Lane 1 read answer wrong.");

  chk_read_no_effect: assert property (@(posedge aclk) disable iff (!aresetn)
    (rd_take && hit(s_axi_araddr, slls_pkg::IDX_LANE1_STATUS) && $stable(sel_in[1]) && $stable(error_threshold)) |=>
      $stable(lane_status[1]))
    else $error("Lane read disturbed status.");

  chk_irq_level: assert property (@(posedge aclk) disable iff (!aresetn)
    1'b1 |=> irq == |(irq_status & $past(irq_mask_q)))
    else $error("Interrupt does not follow status.");

  chk_read_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_take |=> s_axi_rvalid && !s_axi_arready)
    else $error("Read answer not raised after address taken.");

  chk_read_release: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_rvalid && s_axi_rready) |=> !s_axi_rvalid && s_axi_arready)
    else $error("Read channel not released after data taken.");

  chk_write_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_go |=> s_axi_bvalid)
    else $error("Write response not raised.");

  chk_write_release: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_bvalid && s_axi_bready) |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
    else $error("Write channels not released after response.");

  chk_unmapped_read: assert property (@(posedge aclk) disable iff (!aresetn)
    (rd_take && !mapped(s_axi_araddr)) |=> s_axi_rresp == slls_pkg::RESP_SLVERR && s_axi_rdata == slls_pkg::DATA_RST)
    else $error("Unmapped read not refused.");

  chk_mask_write: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_go && hit(aw_addr_q, slls_pkg::IDX_IRQ_MASK) && w_strb_q[0]) |=> irq_mask_q == $past(w_data_q[3:0]))
    else $error("Mask write did not land.");

  chk_status_read: assert property (@(posedge aclk) disable iff (!aresetn)
    status_read |=> s_axi_rdata == {28'h000_0000, $past(irq_status)})
    else $error("Status read did not return value before clear.");

  chk_lane0_codegroup: assert property (@(posedge aclk) disable iff (!aresetn)
    1'b1 |=> lane_status[0][0] == $past(sel_in[0].codegroup_align_ok))
    else $error("Lane 0 code group bit wrong.");

  cov_lane0_read: cover property (@(posedge aclk) disable iff (!aresetn)
    rd_take && hit(s_axi_araddr, slls_pkg::IDX_LANE0_STATUS));
  cov_mask_write: cover property (@(posedge aclk) disable iff (!aresetn)
    wr_go && hit(aw_addr_q, slls_pkg::IDX_IRQ_MASK));
  cov_irq_raise: cover property (@(posedge aclk) disable iff (!aresetn) $rose(irq));
  cov_page_change: cover property (@(posedge aclk) disable iff (!aresetn)
    $changed(link_page));
  cov_unmapped_read: cover property (@(posedge aclk) disable iff (!aresetn)
    rd_take && !mapped(s_axi_araddr));

endmodule

/* tb/slls_top_bench.sv */
`timescale 1ns/100ps
module slls_top_bench;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam logic [13:0] A_L0 = {slls_pkg::IDX_LANE0_STATUS, 2'b00};
  localparam logic [13:0] A_L1 = {slls_pkg::IDX_LANE1_STATUS, 2'b00};
  localparam logic [13:0] A_IS = {slls_pkg::IDX_IRQ_STATUS, 2'b00};
  localparam logic [13:0] A_IM = {slls_pkg::IDX_IRQ_MASK, 2'b00};
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, irq;
  slls_pkg::slls_lane_in_t [1:0][1:0] lane_in;
  logic [7:0] error_threshold;
  logic [0:0] link_page;
  logic [13:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp;
  int n_errors, cmp_count;

  slls_top #(.NUM_LINKS(2)) u_slls_top (
    .aclk(aclk), .aresetn(aresetn), .lane_in(lane_in), .error_threshold(error_threshold),
    .link_page(link_page), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq)
  );

  always #50 aclk = ~aclk;

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tick(inout int n);
    @(posedge aclk);
    n++;
    if (n > 50) begin
      n_errors++;
      $display("wrong value handshake expected answer seen none");
      print_verdict();
    end
  endtask

  task automatic axi_write(input logic [13:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    logic aw_done;
    logic w_done;
    n = 0;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      tick(n);
      if (!aw_done && awready === 1'b1) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_done && wready === 1'b1) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1) tick(n);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [13:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    tick(n);
    while (arready !== 1'b1) tick(n);
    arvalid <= 1'b0;
    tick(n);
    while (rvalid !== 1'b1) tick(n);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic expect_rd(input string nm, input logic [13:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    axi_read(a, d, r);
    check(nm, d, e);
    check({nm, " resp"}, {30'h0, r}, {30'h0, er});
  endtask

  task automatic set_lane(input int k, input int l, input logic [4:0] s, input logic [7:0] d, i, b);
    @(posedge aclk);
    lane_in[k][l] <= '{disparity_cnt: d, invalid_cnt: i, bad_ctrl_cnt: b, deskew_done: s[4],
      initial_align_ok: s[3], checksum_ok: s[2], frame_align_ok: s[1], codegroup_align_ok: s[0]};
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_reset();
    check("irq", {31'h0, irq}, 32'h0000_0000);
    expect_rd("lane0", A_L0, 32'h0000_0000, slls_pkg::RESP_OKAY);
    expect_rd("lane1", A_L1, 32'h0000_0000, slls_pkg::RESP_OKAY);
    expect_rd("mask", A_IM, 32'h0000_0000, slls_pkg::RESP_OKAY);
    $display("test reset done");
  endtask

  task automatic test_sync_bits();
    for (int b = 0; b < 5; b++) begin
      set_lane(0, 0, 5'(1 << b), 8'h00, 8'h00, 8'h00);
      set_lane(0, 1, 5'(1 << (4 - b)), 8'h00, 8'h00, 8'h00);
      expect_rd("lane0 sync", A_L0, 32'(1 << b), slls_pkg::RESP_OKAY);
      expect_rd("lane1 sync", A_L1, 32'(1 << (4 - b)), slls_pkg::RESP_OKAY);
    end
    $display("test sync bits done");
  endtask

  task automatic test_threshold();
    logic [7:0] c;
    logic [7:0] v [3];
    for (int f = 0; f < 3; f++) begin
      for (int j = 0; j < 3; j++) begin
        c = 8'h0f + 8'(j);
        v = '{8'h00, 8'h00, 8'h00};
        v[f] = c;
        set_lane(0, 1, 5'h1f, v[0], v[1], v[2]);
        expect_rd("lane1 flag", A_L1, 32'h1f | (32'(c >= 8'h10) << (7 - f)), slls_pkg::RESP_OKAY);
      end
    end
    error_threshold <= 8'hff;
    set_lane(0, 0, 5'h00, 8'hff, 8'hfe, 8'hff);
    expect_rd("lane0 top", A_L0, 32'h0000_00a0, slls_pkg::RESP_OKAY);
    error_threshold <= 8'h00;
    set_lane(0, 0, 5'h00, 8'h00, 8'h00, 8'h00);
    expect_rd("lane0 zero", A_L0, 32'h0000_00e0, slls_pkg::RESP_OKAY);
    expect_rd("lane0 again", A_L0, 32'h0000_00e0, slls_pkg::RESP_OKAY);
    error_threshold <= 8'h10;
    set_lane(0, 0, 5'h00, 8'h00, 8'h00, 8'h00);
    expect_rd("lane0 live", A_L0, 32'h0000_0000, slls_pkg::RESP_OKAY);
    $display("test threshold done");
  endtask

  task automatic test_paging();
    set_lane(1, 0, 5'h15, 8'h00, 8'h20, 8'h00);
    set_lane(0, 0, 5'h0a, 8'h00, 8'h00, 8'h00);
    link_page <= 1'b1;
    expect_rd("page1 lane0", A_L0, 32'h0000_0055, slls_pkg::RESP_OKAY);
    link_page <= 1'b0;
    expect_rd("page0 lane0", A_L0, 32'h0000_000a, slls_pkg::RESP_OKAY);
    $display("test paging done");
  endtask

  task automatic test_access();
    set_lane(0, 1, 5'h03, 8'h00, 8'h00, 8'h00);
    axi_write(A_L1, 32'h0000_00ff, resp);
    check("lane1 write resp", {30'h0, resp}, {30'h0, slls_pkg::RESP_OKAY});
    expect_rd("lane1 kept", A_L1, 32'h0000_0003, slls_pkg::RESP_OKAY);
    expect_rd("unmapped", 14'h0ff0, 32'h0000_0000, slls_pkg::RESP_SLVERR);
    $display("test access done");
  endtask

  task automatic test_irq();
    logic [31:0] d;
    set_lane(0, 0, 5'h1f, 8'h00, 8'h00, 8'h00);
    axi_read(A_IS, d, resp);
    set_lane(0, 0, 5'h1f, 8'h00, 8'h00, 8'h10);
    repeat (4) @(posedge aclk);
    check("irq masked", {31'h0, irq}, 32'h0000_0000);
    axi_write(A_IM, 32'h0000_0001, resp);
    repeat (3) @(posedge aclk);
    check("irq on", {31'h0, irq}, 32'h0000_0001);
    expect_rd("irq status", A_IS, 32'h0000_0001, slls_pkg::RESP_OKAY);
    repeat (3) @(posedge aclk);
    check("irq off", {31'h0, irq}, 32'h0000_0000);
    expect_rd("irq cleared", A_IS, 32'h0000_0000, slls_pkg::RESP_OKAY);
    set_lane(0, 0, 5'h0f, 8'h00, 8'h00, 8'h10);
    repeat (4) @(posedge aclk);
    check("irq sync masked", {31'h0, irq}, 32'h0000_0000);
    expect_rd("irq sync", A_IS, 32'h0000_0002, slls_pkg::RESP_OKAY);
    $display("test irq done");
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    lane_in = '0;
    error_threshold = 8'h10;
    link_page = 1'b0;
    {awaddr, araddr, wdata, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    n_errors = 0;
    cmp_count = 0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    test_reset();
    test_sync_bits();
    test_threshold();
    test_paging();
    test_access();
    test_irq();
    print_verdict();
  end
endmodule
